// >>> design/mfd_core.sv
/*
 * Panel-meter digital core: sinc4 decimator, result scaling with offset
 * correction, display source priority, digit scan with point and zero blanking.
 * Assumes a modulator bit stream qualified by mod_valid, an AXI4-Lite master.
 */
// Summary of operation
// - input is a single-bit third-order modulator stream; ones density is level
// - bitstream is low-pass filtered with a sinc to the fourth power
// - result counts as settled only after four output periods since a step
// - decimation ratio is 128 for 3.5 digits, 1024 for 4.5 digits
// - output rate equals first notch, 5Hz; notches at its multiples
// - filter timing sized for a 4.9152MHz module clock
// - datapath carries 25% overrange without wrap or saturation
// - offset calibration applied continuously, no host command needed
// - clock-source bit: 0 internal oscillator, 1 external clock
// - clock-source bit reads zero after power-up
// - conversion and display rates scale with the module clock
// - conversion results refresh the display at 2.5Hz nominal
// - display shows results by default, or host-written values
// - segment override drives segments straight from segment registers
// - priority: host value, then held, then peak, then conversion result
// - digits are scanned one at a time, period about 1.9531ms
// - each of five digit slots is on one fifth of the scan
// - point placed by enable bit and two place bits
// - leading zeros blanked, digit left of active point kept lit
// - overrange and underrange detected and flagged separately
// - overrange shows lone one; underrange shows minus one
// - point off when disabled; place codes move it one digit left each
// - end-of-conversion pulses each period unless mod_cal is high; result valid from the edge where it rises
`timescale 1ns/10ps
module mfd_core #(
  parameter int SCAN_CYC = mfd_pkg::SCAN_NS / mfd_pkg::CLK_NS
) (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst,
  // axi4-lite slave
  input  wire  logic [7:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [7:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // modulator side
  input  wire  logic        mod_bit,
  input  wire  logic        mod_valid,
  input  wire  logic        mod_cal,
  output logic              clock_source_select,
  output logic              end_of_conv,
  // display
  output logic [7:0]        segment_drive,
  output logic [4:0]        digit_drive
);
  localparam int SLOT_CYC = SCAN_CYC / mfd_pkg::SLOTS;

  logic [mfd_pkg::CTRL_W-1:0] ctrl_ff;
  logic [mfd_pkg::CNT_W-1:0]  disp_ff;
  logic [39:0]                seg_reg_ff;
  logic                       aw_got_ff, w_got_ff;
  logic [7:0]                 aw_addr_ff;
  logic [31:0]                w_data_ff;
  logic [3:0]                 w_strb_ff;
  logic                       wr_do;
  logic [31:0]                rd_val;
  logic                       rd_hit;

  // write side: address and data caught in either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign wr_do         = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_do) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_ff      <= mfd_pkg::CTRL_RST;
      disp_ff      <= '0;
      seg_reg_ff   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mfd_pkg::RESP_OK;
    end else begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mfd_pkg::RESP_OK;
        case (aw_addr_ff)
          mfd_pkg::OFS_CTRL:  ctrl_ff <= mfd_pkg::CTRL_W'(merge(32'(ctrl_ff), w_data_ff,
                                                                w_strb_ff));
          mfd_pkg::OFS_DISP:  disp_ff <= mfd_pkg::CNT_W'(merge(32'(disp_ff), w_data_ff,
                                                               w_strb_ff));
          mfd_pkg::OFS_SEGLO: seg_reg_ff[31:0] <= merge(seg_reg_ff[31:0], w_data_ff, w_strb_ff);
          mfd_pkg::OFS_SEGHI: seg_reg_ff[39:32] <= w_strb_ff[0] ? w_data_ff[7:0]
                                                                : seg_reg_ff[39:32];
          mfd_pkg::OFS_PEAK:  ;
          default:            s_axi_bresp <= mfd_pkg::RESP_ERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign clock_source_select = ctrl_ff[mfd_pkg::B_CLKSRC];

  // filter: four integrators at bit rate, decimate, four differentiators
  logic                           wide;
  logic [9:0]                     ratio_m1;
  logic [9:0]                     dec_ff;
  logic [mfd_pkg::ACC_W-1:0]      int_ff [4];
  logic [mfd_pkg::ACC_W-1:0]      dif_ff [4];
  logic [mfd_pkg::ACC_W-1:0]      dstage [5];
  logic                           dec_tick;
  logic signed [mfd_pkg::RES_W-1:0] raw, res_new;
  logic signed [mfd_pkg::RES_W-1:0] result_ff, offset_ff;
  logic signed [32:0]             prod;
  logic signed [mfd_pkg::CNT_W-1:0] cnt_new, conv_cnt_ff;
  logic                           over_ff, under_ff, settled_ff, phase_ff, was_wide_ff;
  logic [2:0]                     settle_ff;

  assign wide     = ctrl_ff[mfd_pkg::B_WIDE];
  assign ratio_m1 = wide ? mfd_pkg::RATIO_HI : mfd_pkg::RATIO_LO;
  assign dec_tick = mod_valid && (dec_ff == ratio_m1);

  // two's-complement wrap in the integrators cancels in the differentiators
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_ff <= '0;
      for (int i = 0; i < 4; i++) int_ff[i] <= '0;
    end else if (mod_valid) begin
      dec_ff    <= dec_tick ? 10'h000 : dec_ff + 10'h001;
      int_ff[0] <= int_ff[0] + {40'h0, mod_bit};
      for (int i = 1; i < 4; i++) int_ff[i] <= int_ff[i] + int_ff[i-1];
    end
  end

  always_comb begin
    dstage[0] = int_ff[3];
    for (int i = 0; i < 4; i++) dstage[i+1] = dstage[i] - dif_ff[i];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) dif_ff[i] <= '0;
    end else if (dec_tick) begin
      for (int i = 0; i < 4; i++) dif_ff[i] <= dstage[i];
    end
  end

  // centred and scaled to 21 bits; 25% overrange still fits
  always_comb begin
    logic [mfd_pkg::ACC_W-1:0] c;
    c = dstage[4] - (wide ? mfd_pkg::HALF_HI : mfd_pkg::HALF_LO);
    raw = wide ? mfd_pkg::RES_W'($signed(c) >>> mfd_pkg::SH_HI)
               : mfd_pkg::RES_W'($signed(c) >>> mfd_pkg::SH_LO);
    res_new = raw - offset_ff;
    prod = res_new * $signed({1'b0, wide ? mfd_pkg::MUL_HI : mfd_pkg::MUL_LO});
    cnt_new = wide ? mfd_pkg::CNT_W'(prod >>> mfd_pkg::CSH_HI)
                   : mfd_pkg::CNT_W'(prod >>> mfd_pkg::CSH_LO);
  end

  logic [mfd_pkg::CNT_W-1:0] lim, step;
  assign lim  = wide ? mfd_pkg::LIM_HI : mfd_pkg::LIM_LO;
  assign step = (cnt_new > conv_cnt_ff) ? mfd_pkg::CNT_W'(cnt_new - conv_cnt_ff)
                                        : mfd_pkg::CNT_W'(conv_cnt_ff - cnt_new);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ff   <= '0;
      offset_ff   <= '0;
      conv_cnt_ff <= '0;
      end_of_conv <= 1'b0;
      over_ff     <= 1'b0;
      under_ff    <= 1'b0;
      phase_ff    <= 1'b0;
      settle_ff   <= '0;
      was_wide_ff <= 1'b0;
    end else begin
      end_of_conv <= dec_tick && !mod_cal;
      was_wide_ff <= wide;
      if (dec_tick && mod_cal) begin
        offset_ff <= raw;
      end else if (dec_tick) begin
        result_ff   <= res_new;
        conv_cnt_ff <= cnt_new;
        over_ff     <= $signed(cnt_new) > $signed(lim);
        under_ff    <= $signed(cnt_new) < -$signed(lim);
        phase_ff    <= !phase_ff;
        if ($signed(step) > $signed(mfd_pkg::STEP_LIM)) settle_ff <= '0;
        else if (settle_ff != mfd_pkg::SETTLE_N) settle_ff <= settle_ff + 3'h1;
      end
      if (wide != was_wide_ff) settle_ff <= '0;
    end
  end
  assign settled_ff = (settle_ff == mfd_pkg::SETTLE_N);

  // display sources
  logic signed [mfd_pkg::CNT_W-1:0] shown_ff, peak_ff, held_ff, pre_hold, base;
  logic hold_q_ff;
  logic peak_clr;

  assign peak_clr = wr_do && aw_addr_ff == mfd_pkg::OFS_PEAK;

  always_comb begin
    if (ctrl_ff[mfd_pkg::B_HOST]) pre_hold = disp_ff;
    else if (ctrl_ff[mfd_pkg::B_PEAK]) pre_hold = peak_ff;
    else pre_hold = shown_ff;
    if (ctrl_ff[mfd_pkg::B_HOST]) base = disp_ff;
    else if (ctrl_ff[mfd_pkg::B_HOLD]) base = held_ff;
    else base = pre_hold;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shown_ff  <= '0;
      peak_ff   <= '0;
      held_ff   <= '0;
      hold_q_ff <= 1'b0;
    end else begin
      hold_q_ff <= ctrl_ff[mfd_pkg::B_HOLD];
      if (end_of_conv && phase_ff) shown_ff <= conv_cnt_ff;
      // a result landing with the clear wins, so no new peak is lost
      if (end_of_conv && (conv_cnt_ff > peak_ff || peak_clr)) peak_ff <= conv_cnt_ff;
      else if (peak_clr) peak_ff <= '0;
      if (ctrl_ff[mfd_pkg::B_HOLD] && !hold_q_ff) held_ff <= pre_hold;
    end
  end

  // scan
  logic [14:0] slot_cnt_ff;
  logic [2:0]  slot_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_cnt_ff <= '0;
      slot_ff     <= '0;
    end else if (slot_cnt_ff == 15'(SLOT_CYC - 1)) begin
      slot_cnt_ff <= '0;
      slot_ff     <= (slot_ff == 3'(mfd_pkg::SLOTS - 1)) ? 3'h0 : slot_ff + 3'h1;
    end else begin
      slot_cnt_ff <= slot_cnt_ff + 15'h0001;
    end
  end

  // segment pattern for the current slot
  logic [16:0] mag;
  logic [19:0] bcd;
  logic [2:0]  half, pt_slot;
  logic        neg, d_over, d_under;
  logic [7:0]  nxt_seg;
  always_comb begin
    logic [16:0] m;
    logic [3:0]  d;
    logic        lit;
    m    = '0;
    d    = 4'h0;
    lit  = 1'b0;
    neg  = base[mfd_pkg::CNT_W-1];
    mag  = neg ? 17'(-base) : 17'(base);
    m    = mag;
    bcd  = '0;
    for (int i = 0; i < 17; i++) begin
      for (int k = 0; k < 5; k++) if (bcd[k*4 +: 4] > 4'h4) bcd[k*4 +: 4] += 4'h3;
      bcd = {bcd[18:0], m[16]};
      m   = {m[15:0], 1'b0};
    end
    half    = wide ? 3'h4 : 3'h3;
    pt_slot = 3'({ctrl_ff[mfd_pkg::B_PTHI], ctrl_ff[mfd_pkg::B_PTLO]}) + 3'(wide);
    d_over  = $signed(base) > $signed(lim);
    d_under = $signed(base) < -$signed(lim);
    d       = bcd[slot_ff*4 +: 4];
    lit     = (bcd >> (slot_ff*4)) != 20'h0 || slot_ff == 3'h0 ||
              (ctrl_ff[mfd_pkg::B_PTEN] && slot_ff <= pt_slot);
    nxt_seg = mfd_pkg::SEG_BLANK;
    if (ctrl_ff[mfd_pkg::B_SEGOVR]) begin
      nxt_seg = seg_reg_ff[slot_ff*8 +: 8];
    end else if (d_over || d_under) begin
      if (slot_ff == half) nxt_seg = mfd_pkg::SEG_ONE | (d_under ? mfd_pkg::SEG_MIN
                                                                 : mfd_pkg::SEG_BLANK);
    end else begin
      if (slot_ff == half)
        nxt_seg = (d != 4'h0 ? mfd_pkg::SEG_ONE : mfd_pkg::SEG_BLANK) |
                  (neg ? mfd_pkg::SEG_MIN : mfd_pkg::SEG_BLANK);
      else if (slot_ff < half && lit) nxt_seg = mfd_pkg::mfd_seven(d);
      if (ctrl_ff[mfd_pkg::B_PTEN] && slot_ff == pt_slot) nxt_seg |= mfd_pkg::SEG_DP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      segment_drive <= '0;
      digit_drive   <= '0;
    end else begin
      segment_drive <= nxt_seg;
      digit_drive   <= 5'(5'h01 << slot_ff);
    end
  end

  // read side
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      mfd_pkg::OFS_CTRL:   rd_val = 32'(ctrl_ff);
      mfd_pkg::OFS_DISP:   rd_val = 32'(disp_ff);
      mfd_pkg::OFS_SEGLO:  rd_val = seg_reg_ff[31:0];
      mfd_pkg::OFS_SEGHI:  rd_val = 32'(seg_reg_ff[39:32]);
      mfd_pkg::OFS_RESULT: rd_val = 32'(result_ff);
      mfd_pkg::OFS_STATUS: rd_val = {28'h0, end_of_conv, settled_ff, under_ff, over_ff};
      mfd_pkg::OFS_PEAK:   rd_val = 32'(peak_ff);
      mfd_pkg::OFS_OFFSET: rd_val = 32'(offset_ff);
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= mfd_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? mfd_pkg::RESP_OK : mfd_pkg::RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  eoc_single_a: assert property (end_of_conv |=> !end_of_conv)
    else $error("end of conversion longer than one cycle");
  result_on_eoc_a: assert property (!$stable(result_ff) |-> end_of_conv)
    else $error("result changed outside end of conversion");
  decim_tick_a: assert property (mod_valid && dec_ff == ratio_m1 && !mod_cal
                                 |=> end_of_conv)
    else $error("no result after full decimation count");
  clk_src_a: assert property (!$stable(clock_source_select) |-> $past(wr_do))
    else $error("clock source changed without a write");
  digit_one_a: assert property ($onehot(digit_drive) || $past(rst))
    else $error("digit drive not one-hot");
  slot_time_a: assert property (slot_cnt_ff <= 15'(SLOT_CYC - 1) and
                                (!$stable(slot_ff) |-> $past(slot_cnt_ff) ==
                                 15'(SLOT_CYC - 1)))
    else $error("digit slot time wrong");
  seg_over_a: assert property (ctrl_ff[mfd_pkg::B_SEGOVR] |=>
                               segment_drive == $past(seg_reg_ff[slot_ff*8 +: 8]))
    else $error("segment override not followed");
  refresh_a: assert property (!$stable(shown_ff) |-> $past(end_of_conv && phase_ff))
    else $error("display refreshed off cadence");
  range_flag_a: assert property (!(over_ff && under_ff))
    else $error("over and under flagged together");
  hold_keep_a: assert property (ctrl_ff[mfd_pkg::B_HOLD] && hold_q_ff
                                |=> $stable(held_ff))
    else $error("held value moved during hold");
  override_c: cover property (ctrl_ff[mfd_pkg::B_SEGOVR] && end_of_conv);
  over_c:     cover property (end_of_conv ##1 over_ff);
  hold_c:     cover property ($rose(ctrl_ff[mfd_pkg::B_HOLD]) ##1 end_of_conv);
endmodule

// >>> design/mfd_pkg.sv
/*
 * Constants for the panel-meter core: register map, control bits, filter and
 * display timing, seven-segment codes.
 * Assumes a 10 MHz system clock and AXI4-Lite with 32-bit data.
 */
package mfd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DISP   = 8'h04;
  localparam logic [7:0] OFS_SEGLO  = 8'h08;
  localparam logic [7:0] OFS_SEGHI  = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PEAK   = 8'h18;
  localparam logic [7:0] OFS_OFFSET = 8'h1c;
  // control bit positions
  localparam int B_CLKSRC = 0;
  localparam int B_SEGOVR = 1;
  localparam int B_HOST   = 2;
  localparam int B_HOLD   = 3;
  localparam int B_PEAK   = 4;
  localparam int B_PTEN   = 5;
  localparam int B_PTHI   = 6;
  localparam int B_PTLO   = 7;
  localparam int B_WIDE   = 8;
  localparam int CTRL_W   = 9;
  localparam logic [8:0] CTRL_RST = 9'h100;
  // filter
  localparam int          ACC_W    = 41;
  localparam int          RES_W    = 21;
  localparam int          CNT_W    = 18;
  localparam logic [9:0]  RATIO_LO = 10'h07f;
  localparam logic [9:0]  RATIO_HI = 10'h3ff;
  localparam logic [40:0] HALF_LO  = 41'h000_0800_0000;
  localparam logic [40:0] HALF_HI  = 41'h080_0000_0000;
  localparam int          SH_LO    = 8;
  localparam int          SH_HI    = 20;
  localparam logic [11:0] MUL_LO   = 12'h271;
  localparam logic [11:0] MUL_HI   = 12'hc35;
  localparam int          CSH_LO   = 17;
  localparam int          CSH_HI   = 16;
  localparam logic [17:0] LIM_LO   = 18'h007cf;
  localparam logic [17:0] LIM_HI   = 18'h04e1f;
  localparam logic [17:0] STEP_LIM = 18'h00064;
  localparam logic [2:0]  SETTLE_N = 3'h4;
  // display and bus responses
  localparam int          CLK_NS   = 100;
  localparam int          SCAN_NS  = 1953100;
  localparam int          SLOTS    = 5;
  localparam logic [7:0]  SEG_ONE  = 8'h06;
  localparam logic [7:0]  SEG_MIN  = 8'h40;
  localparam logic [7:0]  SEG_DP   = 8'h80;
  localparam logic [7:0]  SEG_BLANK = 8'h00;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  function automatic logic [7:0] mfd_seven(input logic [3:0] d);
    case (d)
      4'h0: mfd_seven = 8'h3f;
      4'h1: mfd_seven = 8'h06;
      4'h2: mfd_seven = 8'h5b;
      4'h3: mfd_seven = 8'h4f;
      4'h4: mfd_seven = 8'h66;
      4'h5: mfd_seven = 8'h6d;
      4'h6: mfd_seven = 8'h7d;
      4'h7: mfd_seven = 8'h07;
      4'h8: mfd_seven = 8'h7f;
      4'h9: mfd_seven = 8'h6f;
      default: mfd_seven = 8'h00;
    endcase
  endfunction
endpackage

// >>> verif/mfd_display_model.sv
/*
 * Display model: keeps the segment pattern last seen in each digit slot and
 * counts scan faults. Assumes one-hot digit drive and a fixed slot length.
 */
`timescale 1ns/10ps
module mfd_display_model #(
  parameter int SLOT_CYC = 10
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // display pins
  input  wire logic [7:0] segment_drive,
  input  wire logic [4:0] digit_drive,
  // observations
  output logic      [7:0] slot_seg [5],
  output int              bad_cnt
);
  logic [4:0] prev_ff;
  int         run_ff;
  logic       seen_ff;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 5'h00;
      run_ff <= 0;
      seen_ff <= 1'b0;
      bad_cnt <= 0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (digit_drive[i]) begin
          slot_seg[i] <= segment_drive;
        end
      end
      // drive is still zero one edge after reset and the first slot may be short,
      // so timing starts one change later
      if ((prev_ff != 5'h00 && !$onehot(digit_drive)) ||
          (seen_ff && digit_drive != prev_ff &&
          (run_ff != SLOT_CYC || digit_drive != {prev_ff[3:0], prev_ff[4]}))) begin
        bad_cnt <= bad_cnt + 1;
      end
      if (digit_drive != prev_ff) begin
        seen_ff <= (prev_ff != 5'h00);
        run_ff <= 1;
      end else begin
        run_ff <= run_ff + 1;
      end
      prev_ff <= digit_drive;
    end
  end
endmodule

// >>> verif/test_meter_filter_display_core.sv
/*
 * Bench for the panel-meter core: registers over AXI4-Lite, display sources,
 * point and blanking, conversion timing and range flags.
 * Assumes SCAN_CYC of 50, so each digit slot lasts 10 clocks.
 */
`timescale 1ns/10ps
module test_meter_filter_display_core;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, mod_bit, mod_run, mod_cal;
  logic        awready, wready, bvalid, arready, rvalid, clksel, eoc, mod_valid;
  logic [7:0]  awaddr, araddr, seg, slot_seg [5];
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rsp;
  logic [4:0]  dig;
  int          n_fail, compares, bad_cnt;

  mfd_core #(.SCAN_CYC(50)) u_mfd_core (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .mod_bit(mod_bit), .mod_valid(mod_valid), .mod_cal(mod_cal),
    .clock_source_select(clksel), .end_of_conv(eoc), .segment_drive(seg),
    .digit_drive(dig));
  mfd_display_model #(.SLOT_CYC(10)) u_mfd_display_model (
    .clk(clk), .rst(rst), .segment_drive(seg), .digit_drive(dig),
    .slot_seg(slot_seg), .bad_cnt(bad_cnt));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // modulator samples every other clock: 5 MHz, inside the external clock limit
  always @(posedge clk) mod_valid <= mod_run && !mod_valid;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // handshakes are sampled at the falling edge, where the pre-edge values stand
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    int   t;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    hb = 1'b0;
    t = 0;
    while (!hb && t < 200) begin
      @(negedge clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      rsp = bresp;
      t++;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
    chk(hb, 1, "write hang");
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic ha, hr;
    int   t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    hr = 1'b0;
    t = 0;
    while (!hr && t < 200) begin
      @(negedge clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      rd = rdata;
      rsp = rresp;
      t++;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
    chk(hr, 1, "read hang");
  endtask
  task automatic chk_slots(input logic [39:0] e, input int n);
    repeat (120) @(posedge clk);
    for (int i = 0; i < n; i++) chk(slot_seg[i], e[8*i+:8], "slot");
  endtask
  task automatic wait_eoc(output int cyc);
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (eoc !== 1'b1 && cyc < 3000);
    @(posedge clk);
  endtask

  task automatic t_regs;
    axi_rd(mfd_pkg::OFS_CTRL);
    chk(rd, 32'h0000_0100, "ctrl reset");
    chk(clksel, 1'b0, "clock source reset");
    axi_wr(mfd_pkg::OFS_CTRL, 32'h0000_0101);
    chk(clksel, 1'b1, "clock source set");
    axi_wr(8'h40, 32'h0000_0001);
    chk(rsp, mfd_pkg::RESP_ERR, "unmapped write");
    axi_rd(8'h40);
    chk(rsp, mfd_pkg::RESP_ERR, "unmapped read");
    chk(rd, 32'h0000_0000, "unmapped read data");
    $display("test regs done");
  endtask
  task automatic t_sources;
    logic [39:0] e;
    axi_wr(mfd_pkg::OFS_SEGLO, 32'h4f5b_063f);
    axi_wr(mfd_pkg::OFS_SEGHI, 32'h0000_0066);
    // override wins even with host, hold and peak all set
    axi_wr(mfd_pkg::OFS_CTRL, 32'h0000_011e);
    chk_slots(40'h66_4f5b_063f, 5);
    axi_wr(mfd_pkg::OFS_DISP, 32'h0000_0005);
    axi_wr(mfd_pkg::OFS_CTRL, 32'h0000_01d4);
    chk_slots(40'h00_0000_006d, 4);
    // hold captures the host value, then keeps it once host select drops
    axi_wr(mfd_pkg::OFS_CTRL, 32'h0000_010c);
    axi_wr(mfd_pkg::OFS_CTRL, 32'h0000_0108);
    chk_slots(40'h00_0000_006d, 1);
    axi_wr(mfd_pkg::OFS_DISP, 32'h0000_0000);
    for (int c = 0; c < 3; c++) begin
      axi_wr(mfd_pkg::OFS_CTRL, 32'h124 | (c[1] << 6) | (c[0] << 7));
      e = 40'h0;
      for (int i = 0; i <= c + 1; i++) e[8*i+:8] = (i == c + 1) ? 8'hbf : 8'h3f;
      chk_slots(e, 4);
    end
    $display("test sources done");
  endtask
  task automatic t_conv(input logic wide, input logic b);
    int c;
    axi_wr(mfd_pkg::OFS_CTRL, {23'h0, wide, 8'h00});
    mod_bit <= b;
    mod_run <= 1'b1;
    wait_eoc(c);
    wait_eoc(c);
    chk(c, 2 * (wide ? 1024 : 128), "conversion period");
    repeat (10) wait_eoc(c);
    axi_rd(mfd_pkg::OFS_STATUS);
    chk(rd[2:0], b ? 3'b101 : 3'b110, "range flags");
    // from reset the step response rises monotonically to full ones
    if (!wide && b) begin
      axi_rd(mfd_pkg::OFS_PEAK);
      chk(rd, 32'h0000_09c4, "peak value");
    end
    chk_slots(40'h0, 1);
    chk(slot_seg[wide ? 4 : 3], b ? 8'h06 : 8'h46, "range display");
    $display("test conversion done");
  endtask
  // all-ones stream in wide mode: raw is half of full range, offset takes it all
  task automatic t_cal;
    int c;
    mod_cal <= 1'b1;
    repeat (2100) @(posedge clk);
    mod_cal <= 1'b0;
    wait_eoc(c);
    wait_eoc(c);
    axi_rd(mfd_pkg::OFS_OFFSET);
    chk(rd, 32'h0008_0000, "offset captured");
    axi_rd(mfd_pkg::OFS_RESULT);
    chk(rd, 32'h0000_0000, "corrected result");
    chk_slots(40'h00_0000_003f, 2);
    $display("test calibration done");
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, mod_bit, mod_run, mod_cal} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    n_fail = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_sources();
    t_conv(1'b0, 1'b1);
    t_conv(1'b0, 1'b0);
    t_conv(1'b1, 1'b1);
    t_cal();
    chk(bad_cnt, 0, "scan faults");
    tally_and_finish();
  end
  initial begin
    #6_000_000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
